/* inc/sensor_status_result_regs.svh */
`ifndef SENSOR_STATUS_RESULT_REGS_SVH
`define SENSOR_STATUS_RESULT_REGS_SVH

// Register offsets (word index on the serial port)
`define CONV_STATE_WORD_OFS 4'h8
`define X_AXIS_RESULT_OFS 4'h9
`define Y_AXIS_RESULT_OFS 4'hA
`define Z_AXIS_RESULT_OFS 4'hB
`define THERMOMETER_RESULT_OFS 4'hC
`define FRONTEND_DIAG_WORD_OFS 4'hD

// Reset values
`define CONV_STATE_WORD_RST 16'h0000
`define RESULT_RST 16'h0000
`define FRONTEND_DIAG_WORD_RST 16'h8000

// conversion_state_word fields
`define CSW_READY_BIT 13
`define CSW_ANGLE_BIT 12
`define CSW_TEMP_BIT 11
`define CSW_Z_BIT 10
`define CSW_Y_BIT 9
`define CSW_X_BIT 8
`define CSW_COUNT_MSB 6
`define CSW_COUNT_LSB 4
`define CSW_CAUSE_MSB 1
`define CSW_CAUSE_LSB 0

// frontend_diag_word fields
`define FDW_POWERUP_BIT 15
`define FDW_SENS_BIT 12
`define FDW_TEMP_BIT 11
`define FDW_Z_BIT 10
`define FDW_Y_BIT 9
`define FDW_X_BIT 8
`define FDW_TRIM_BIT 1
`define FDW_REG_BIT 0

`endif

/* inc/sensor_status_result_pkg.sv */
package sensor_status_result_pkg;

	typedef logic [15:0] word_t;

	typedef logic [3:0] reg_index_t;

	typedef enum logic [1:0] {
		CAUSE_NONE,
		CAUSE_FRONTEND,
		CAUSE_SYSTEM,
		CAUSE_BOTH
	} interrupt_cause_code_t;

endpackage

/* verilog/clear_on_read_flags.sv */
`timescale 1ns/1ps

module clear_on_read_flags #(
	parameter int WIDTH = 8,
	parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] set_evt,
	input wire logic read_clear,
	output logic [WIDTH-1:0] flags_reg
);

	logic [WIDTH-1:0] flags_next;

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_flag
			// Set beats the clear so an event landing on the read is kept
			assign flags_next[i] = set_evt[i] | (flags_reg[i] & ~read_clear);
		end
	endgenerate

	// One process owns the whole vector, so no bit has two drivers
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			flags_reg <= RESET_VALUE;
		end else begin
			flags_reg <= flags_next;
		end
	end

endmodule

/* verilog/sensor_status_result_regs.sv */
// Summary of operation
// [RULE_01] Ready bit 13 set when full set valid
// [RULE_02] Bit 12 marks angle/magnitude from latest conversion
// [RULE_03] Bit 11 marks temperature from latest conversion
// [RULE_04] Bits 10..8 mark Z, Y, X current
// [RULE_05] Bits 6..4 count sets, wrap modulo eight
// [RULE_06] Bits 1..0 give alert cause code
// [RULE_07] X, Y, Z results read-only, reset zero
// [RULE_08] Temperature result read-only, reset zero
// [RULE_09] Power-up bit 15 set, cleared by read
// [RULE_10] Bit 12 set on front-end diagnostic fail
// [RULE_11] Bit 11 set on temperature diagnostic fail
// [RULE_12] Bits 10..8 set on Z, Y, X fail
// [RULE_13] Bit 1 set on trim data error
// [RULE_14] Bit 0 set on regulator power fault
// [RULE_15] Fault flags sticky until read, read returns pre-clear
// [RULE_16] Reserved bits zero, writes ignored
`timescale 1ns/1ps
`include "sensor_status_result_regs.svh"

module sensor_status_result_regs #(
	parameter int RESULT_WIDTH = 16,
	parameter int COUNT_WIDTH = 3
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic conv_start,
	input wire logic set_done,
	input wire logic x_updated,
	input wire logic y_updated,
	input wire logic z_updated,
	input wire logic temp_updated,
	input wire logic angle_updated,
	input wire logic [RESULT_WIDTH-1:0] x_data,
	input wire logic [RESULT_WIDTH-1:0] y_data,
	input wire logic [RESULT_WIDTH-1:0] z_data,
	input wire logic [RESULT_WIDTH-1:0] temp_data,
	input wire logic power_loss_evt,
	input wire logic frontend_diag_fail,
	input wire logic temp_diag_fail,
	input wire logic z_hall_diag_fail,
	input wire logic y_hall_diag_fail,
	input wire logic x_hall_diag_fail,
	input wire logic trim_error,
	input wire logic regulator_fault_flag,
	input wire logic system_flag_any,
	input wire logic rd_req,
	input wire logic [3:0] rd_addr,
	output logic [15:0] rd_data_reg,
	output logic rd_valid_reg,
	output logic rd_unmapped_reg,
	output logic result_ready_reg,
	output logic [1:0] interrupt_cause_code_reg
);

	localparam int NCH = 4;

	// Reset release synchroniser
	logic rst_meta_reg;
	logic rst_sync_reg;
	logic rst_core_n;

	// Raw rst_n asserts at once; only its release is retimed
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
		end
	end

	// Only this stage reads the first one
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_sync_reg <= 1'b0;
		end else begin
			rst_sync_reg <= rst_meta_reg;
		end
	end

	assign rst_core_n = rst_sync_reg;

	// Address decode
	wire sel_conv;
	wire sel_x;
	wire sel_y;
	wire sel_z;
	wire sel_temp;
	wire sel_diag;
	wire sel_any;
	wire diag_read;
	wire unmapped_read;

	assign sel_conv = (rd_addr == `CONV_STATE_WORD_OFS);
	assign sel_x = (rd_addr == `X_AXIS_RESULT_OFS);
	assign sel_y = (rd_addr == `Y_AXIS_RESULT_OFS);
	assign sel_z = (rd_addr == `Z_AXIS_RESULT_OFS);
	assign sel_temp = (rd_addr == `THERMOMETER_RESULT_OFS);
	assign sel_diag = (rd_addr == `FRONTEND_DIAG_WORD_OFS);
	assign sel_any = sel_conv | sel_x | sel_y | sel_z | sel_temp | sel_diag;
	assign diag_read = rd_req & sel_diag;
	assign unmapped_read = rd_req & ~sel_any;

	// Result capture, one lane per channel: X, Y, Z, temperature
	logic [RESULT_WIDTH-1:0] ch_data [NCH];
	logic [RESULT_WIDTH-1:0] ch_result_reg [NCH];
	logic [NCH-1:0] ch_updated;
	logic [NCH-1:0] ch_current_reg;
	logic [NCH-1:0] ch_current_next;

	assign ch_data[0] = x_data;
	assign ch_data[1] = y_data;
	assign ch_data[2] = z_data;
	assign ch_data[3] = temp_data;
	assign ch_updated = {temp_updated, z_updated, y_updated, x_updated};

	genvar c;
	generate
		for (c = 0; c < NCH; c++) begin : g_chan
			// Channels not in this set keep their old value and go stale
			always_ff @(posedge core_clk or negedge rst_core_n) begin
				if (!rst_core_n) begin
					ch_result_reg[c] <= RESULT_WIDTH'(`RESULT_RST); // RULE_07
				end else if (set_done && ch_updated[c]) begin
					ch_result_reg[c] <= ch_data[c]; // RULE_07
				end
			end
			assign ch_current_next[c] = set_done ? ch_updated[c] : ch_current_reg[c]; // RULE_04
		end
	endgenerate

	always_ff @(posedge core_clk or negedge rst_core_n) begin
		if (!rst_core_n) begin
			ch_current_reg <= '0;
		end else begin
			ch_current_reg <= ch_current_next; // RULE_03
		end
	end

	// Angle/magnitude currency
	// Stale until a set that carries angle data lands
	logic angle_current_reg;
	wire angle_current_next;

	assign angle_current_next = set_done ? angle_updated : angle_current_reg; // RULE_02

	always_ff @(posedge core_clk or negedge rst_core_n) begin
		if (!rst_core_n) begin
			angle_current_reg <= 1'b0;
		end else begin
			angle_current_reg <= angle_current_next;
		end
	end

	// Ready: dropped when a new conversion starts, raised when its set lands
	logic ready_reg;
	wire ready_next;

	// Set wins, so a start on the finishing edge keeps the set
	assign ready_next = set_done | (ready_reg & ~conv_start); // RULE_01

	always_ff @(posedge core_clk or negedge rst_core_n) begin
		if (!rst_core_n) begin
			ready_reg <= 1'b0;
		end else begin
			ready_reg <= ready_next;
		end
	end

	// Rolling set count, natural wrap
	logic [COUNT_WIDTH-1:0] set_count_reg;
	wire [COUNT_WIDTH-1:0] set_count_inc;
	wire [COUNT_WIDTH-1:0] set_count_next;

	// Three bits wrap by themselves, modulo eight
	assign set_count_inc = set_count_reg + COUNT_WIDTH'(1); // RULE_05
	assign set_count_next = set_done ? set_count_inc : set_count_reg; // RULE_05

	always_ff @(posedge core_clk or negedge rst_core_n) begin
		if (!rst_core_n) begin
			set_count_reg <= '0;
		end else begin
			set_count_reg <= set_count_next;
		end
	end

	// Front-end diagnostic flags, clear on read
	logic [15:0] diag_set;
	logic [15:0] diag_flags;

	always_comb begin
		diag_set = 16'h0000;
		diag_set[`FDW_POWERUP_BIT] = power_loss_evt; // RULE_09
		diag_set[`FDW_SENS_BIT] = frontend_diag_fail; // RULE_10
		diag_set[`FDW_TEMP_BIT] = temp_diag_fail; // RULE_11
		diag_set[`FDW_Z_BIT] = z_hall_diag_fail; // RULE_12
		diag_set[`FDW_Y_BIT] = y_hall_diag_fail; // RULE_12
		diag_set[`FDW_X_BIT] = x_hall_diag_fail; // RULE_12
		diag_set[`FDW_TRIM_BIT] = trim_error; // RULE_13
		diag_set[`FDW_REG_BIT] = regulator_fault_flag; // RULE_14
	end

	// Reserved bits never get a set source, so they stay zero
	clear_on_read_flags #(
		.WIDTH(16),
		.RESET_VALUE(`FRONTEND_DIAG_WORD_RST)
	) u_diag_flags (
		.core_clk(core_clk),
		.rst_n(rst_core_n),
		.set_evt(diag_set),
		.read_clear(diag_read), // RULE_15
		.flags_reg(diag_flags)
	);

	// Alert cause from the live flag state
	wire frontend_any;
	wire [1:0] cause_bits;
	sensor_status_result_pkg::interrupt_cause_code_t cause_now;

	// Power-up bit counts as a front-end flag, so cause reads 1 after reset
	assign frontend_any = |diag_flags;
	assign cause_bits = {system_flag_any, frontend_any}; // RULE_06
	assign cause_now = sensor_status_result_pkg::interrupt_cause_code_t'(cause_bits); // RULE_06

	// Word assembly
	// Reserved positions keep the zero reset pattern
	sensor_status_result_pkg::word_t conv_word;
	sensor_status_result_pkg::word_t x_word;
	sensor_status_result_pkg::word_t y_word;
	sensor_status_result_pkg::word_t z_word;
	sensor_status_result_pkg::word_t temp_word;

	always_comb begin
		conv_word = `CONV_STATE_WORD_RST; // RULE_16
		conv_word[`CSW_READY_BIT] = ready_reg; // RULE_01
		conv_word[`CSW_ANGLE_BIT] = angle_current_reg; // RULE_02
		conv_word[`CSW_TEMP_BIT] = ch_current_reg[3]; // RULE_03
		conv_word[`CSW_Z_BIT] = ch_current_reg[2]; // RULE_04
		conv_word[`CSW_Y_BIT] = ch_current_reg[1]; // RULE_04
		conv_word[`CSW_X_BIT] = ch_current_reg[0]; // RULE_04
		conv_word[`CSW_COUNT_MSB:`CSW_COUNT_LSB] = set_count_reg; // RULE_05
		conv_word[`CSW_CAUSE_MSB:`CSW_CAUSE_LSB] = cause_now; // RULE_06
	end

	// Narrower results sit low, upper bits zero
	assign x_word = 16'(ch_result_reg[0]); // RULE_07
	assign y_word = 16'(ch_result_reg[1]); // RULE_07
	assign z_word = 16'(ch_result_reg[2]); // RULE_07
	assign temp_word = 16'(ch_result_reg[3]); // RULE_08

	// Read mux; no write path exists so these words cannot be altered
	sensor_status_result_pkg::word_t rd_mux;

	assign rd_mux = sel_conv ? conv_word :
		sel_x ? x_word :
		sel_y ? y_word :
		sel_z ? z_word :
		sel_temp ? temp_word :
		sel_diag ? diag_flags : 16'h0000; // RULE_16

	// Read answer; the diag word is captured before its clear lands
	always_ff @(posedge core_clk or negedge rst_core_n) begin
		if (!rst_core_n) begin
			rd_data_reg <= 16'h0000;
		end else if (rd_req) begin
			rd_data_reg <= rd_mux; // RULE_15
		end
	end

	// One-cycle strobe, so each answer is seen once
	always_ff @(posedge core_clk or negedge rst_core_n) begin
		if (!rst_core_n) begin
			rd_valid_reg <= 1'b0;
		end else begin
			rd_valid_reg <= rd_req;
		end
	end

	always_ff @(posedge core_clk or negedge rst_core_n) begin
		if (!rst_core_n) begin
			rd_unmapped_reg <= 1'b0;
		end else begin
			rd_unmapped_reg <= unmapped_read; // RULE_16
		end
	end

	// Status pins mirrored for the alert logic outside
	always_ff @(posedge core_clk or negedge rst_core_n) begin
		if (!rst_core_n) begin
			result_ready_reg <= 1'b0;
		end else begin
			result_ready_reg <= ready_next; // RULE_01
		end
	end

	// Cause pin trails the live flags by one cycle
	always_ff @(posedge core_clk or negedge rst_core_n) begin
		if (!rst_core_n) begin
			interrupt_cause_code_reg <= 2'h0;
		end else begin
			interrupt_cause_code_reg <= cause_now; // RULE_06
		end
	end

endmodule

/* tb/ssr_chk.sv */
`timescale 1ns/1ps
module ssr_chk(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic conv_start,
	input wire logic set_done,
	input wire logic trim_error,
	input wire logic system_flag_any,
	input wire logic rd_req,
	input wire logic [3:0] rd_addr,
	input wire logic [15:0] rd_data_reg,
	input wire logic rd_valid_reg,
	input wire logic rd_unmapped_reg,
	input wire logic result_ready_reg,
	input wire logic [1:0] interrupt_cause_code_reg
);
	logic [1:0] up_reg;
	logic live;
	// Core reset trails rst_n by two edges
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			up_reg <= 2'h0;
		else if (!live)
			up_reg <= up_reg + 2'h1;
	end
	assign live = up_reg == 2'h3;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	property p_ans; live && rd_req |=> rd_valid_reg; endproperty
	a_ans: assert property (p_ans) else $error("read lost");
	property p_one; !rd_req |=> !rd_valid_reg; endproperty
	a_one: assert property (p_one) else $error("stray answer");
	property p_unm; live && rd_req && (rd_addr < 4'h8 || rd_addr > 4'hD) |=> rd_unmapped_reg && rd_data_reg == 16'h0000;
	endproperty
	a_unm: assert property (p_unm) else $error("unmapped read");
	property p_csw; rd_valid_reg && $past(rd_addr) == 4'h8 |-> rd_data_reg[15:14] == 2'h0 && !rd_data_reg[7]
		&& rd_data_reg[3:2] == 2'h0 && rd_data_reg[13] == $past(result_ready_reg); endproperty
	a_csw: assert property (p_csw) else $error("status word");
	property p_rdy; live && set_done |=> result_ready_reg; endproperty
	a_rdy: assert property (p_rdy) else $error("ready not set");
	property p_clr; live && conv_start && !set_done |=> !result_ready_reg; endproperty
	a_clr: assert property (p_clr) else $error("ready not cleared");
	property p_sys; live && system_flag_any |=> interrupt_cause_code_reg[1]; endproperty
	a_sys: assert property (p_sys) else $error("system cause");
	property p_trim; live && trim_error |-> ##2 interrupt_cause_code_reg[0]; endproperty
	a_trim: assert property (p_trim) else $error("trim cause");
endmodule
bind sensor_status_result_regs ssr_chk i_ssr_chk(.core_clk, .rst_n, .conv_start, .set_done, .trim_error,
	.system_flag_any, .rd_req, .rd_addr, .rd_data_reg, .rd_valid_reg, .rd_unmapped_reg, .result_ready_reg,
	.interrupt_cause_code_reg);

/* tb/ssr_host.sv */
`timescale 1ns/1ps
module ssr_host(
	input wire logic core_clk,
	output logic rd_req,
	output logic [3:0] rd_addr,
	input wire logic [15:0] rd_data_reg
);
	initial begin
		rd_req = 1'b0;
		rd_addr = 4'h0;
	end
	// Taken at one rising edge, answer sampled at the falling edge half a cycle later
	task automatic read(input logic [3:0] a, output logic [15:0] d);
		@(negedge core_clk);
		rd_req = 1'b1;
		rd_addr = a;
		@(negedge core_clk);
		rd_req = 1'b0;
		rd_addr = ~a;
		d = rd_data_reg;
	endtask
endmodule

/* tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic conv_start = 1'b0;
	logic set_done = 1'b0;
	logic sys = 1'b0;
	logic [4:0] upd = 5'h00;
	logic [7:0] dg = 8'h00;
	logic [15:0] xd = 16'h8001;
	logic [15:0] yd = 16'hFFFF;
	logic [15:0] zd = 16'h0001;
	logic [15:0] td = 16'h7FFE;
	logic [15:0] rdat, d;
	logic [3:0] rd_addr;
	logic rd_req, rdy;
	int miscompares = 0;
	int n_compared = 0;
	logic [15:0] bitv [8] = '{16'h0001, 16'h0002, 16'h0100, 16'h0200, 16'h0400, 16'h0800, 16'h1000, 16'h8000};
	always #5 core_clk = ~core_clk;
	sensor_status_result_regs i_sensor_status_result_regs(.core_clk, .rst_n, .conv_start, .set_done,
		.x_updated(upd[0]), .y_updated(upd[1]), .z_updated(upd[2]), .temp_updated(upd[3]), .angle_updated(upd[4]),
		.x_data(xd), .y_data(yd), .z_data(zd), .temp_data(td), .power_loss_evt(dg[7]), .frontend_diag_fail(dg[6]),
		.temp_diag_fail(dg[5]), .z_hall_diag_fail(dg[4]), .y_hall_diag_fail(dg[3]), .x_hall_diag_fail(dg[2]),
		.trim_error(dg[1]), .regulator_fault_flag(dg[0]), .system_flag_any(sys), .rd_req, .rd_addr,
		.rd_data_reg(rdat), .rd_valid_reg(), .rd_unmapped_reg(), .result_ready_reg(rdy),
		.interrupt_cause_code_reg());
	ssr_host i_ssr_host(.core_clk, .rd_req, .rd_addr, .rd_data_reg(rdat));
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: %h not %h", $time, got, exp);
		end
	endtask
	task automatic rd(input logic [3:0] a, input logic [15:0] exp);
		i_ssr_host.read(a, d);
		chk(d, exp);
	endtask
	task automatic conv(input logic [4:0] u, input logic [15:0] exp);
		@(negedge core_clk);
		conv_start = 1'b1;
		@(negedge core_clk);
		conv_start = 1'b0;
		set_done = 1'b1;
		upd = u;
		chk({15'h0000, rdy}, 16'h0000);
		@(negedge core_clk);
		set_done = 1'b0;
		upd = ~u;
		chk({15'h0000, rdy}, 16'h0001);
		rd(4'h8, exp);
	endtask
	task automatic t_reset;
		// Power-up flag already gives cause 1
		rd(4'h8, 16'h0001);
		for (int i = 9; i < 13; i++) begin
			rd(i[3:0], 16'h0000);
		end
		rd(4'hD, 16'h8000);
		rd(4'hD, 16'h0000);
		rd(4'hE, 16'h0000);
	endtask
	task automatic t_conv;
		conv(5'h09, 16'h2910);
		xd = 16'h0F0F;
		conv(5'h16, 16'h3620);
		rd(4'h9, 16'h8001);
		rd(4'hA, 16'hFFFF);
		rd(4'hB, 16'h0001);
		rd(4'hC, 16'h7FFE);
		for (int i = 3; i < 9; i++) begin
			conv(5'h00, {9'h040, i[2:0], 4'h0});
		end
	endtask
	task automatic t_diag;
		for (int i = 0; i < 8; i++) begin
			@(negedge core_clk);
			dg[i] = 1'b1;
			@(negedge core_clk);
			dg[i] = 1'b0;
			rd(4'h8, 16'h2001);
			rd(4'hD, bitv[i]);
			rd(4'hD, 16'h0000);
		end
		sys = 1'b1;
		rd(4'h8, 16'h2002);
		dg[1] = 1'b1;
		rd(4'h8, 16'h2003);
		dg[1] = 1'b0;
		sys = 1'b0;
		rd(4'hD, 16'h0002);
		// Event on the read edge survives the clear but misses that read
		fork
			i_ssr_host.read(4'hD, d);
			begin
				@(negedge core_clk);
				dg[0] = 1'b1;
				@(negedge core_clk);
				dg[0] = 1'b0;
			end
		join
		chk(d, 16'h0000);
		rd(4'hD, 16'h0001);
		rd(4'hD, 16'h0000);
	endtask
	task automatic t_rerst;
		@(negedge core_clk);
		rst_n = 1'b0;
		repeat (2) @(negedge core_clk);
		rst_n = 1'b1;
		repeat (3) @(posedge core_clk);
		rd(4'h9, 16'h0000);
		rd(4'h8, 16'h0001);
		rd(4'hD, 16'h8000);
	endtask
	task automatic tally_and_finish;
		$display("compared %0d, miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		repeat (2) @(negedge core_clk);
		rst_n = 1'b1;
		repeat (3) @(posedge core_clk);
		t_reset();
		t_conv();
		t_diag();
		t_rerst();
		tally_and_finish();
	end
	// Whole run needs well under a thousand cycles
	initial begin
		#20000;
		miscompares++;
		tally_and_finish();
	end
endmodule
